// ---- hdl/phs_consts.svh ----
// constants for the proximity switch homing sequencer
`ifndef PHS_CONSTS_SVH
`define PHS_CONSTS_SVH
`define PHS_METHOD_REAR 4'h5
`define PHS_METHOD_FRONT 4'h6
`define PHS_DIG_METHOD_LSB 0
`define PHS_DIG_DIR_LSB 4
`define PHS_DIG_POL_LSB 8
`define PHS_FILT_UNIT_CYC 16'h0014
`define PHS_SEL_HOMING 3'h0
`define PHS_ZERO32 32'h00000000
`define PHS_ZERO16 16'h0000
`define PHS_ONE16 16'h0001
`endif

// ---- hdl/phs_pkg.sv ----
// types of the proximity switch homing sequencer
package phs_pkg;
    typedef enum logic [2:0] {
        PHS_IDLE,
        PHS_FAST,
        PHS_CREEP,
        PHS_WAIT_REAR,
        PHS_TRAVEL,
        PHS_DONE
    } phs_state_t;
endpackage

// ---- hdl/phs_input_filter.sv ----
// input filter delaying one level by a programmable count of 1 us units
`timescale 1ns/1ns
`default_nettype none
`include "phs_consts.svh"
module phs_input_filter
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_filt_units,
    input wire logic i_raw,
    output logic o_filt
);
    logic filt_reg;
    logic filt_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] limit;

    // limit in cycles; zero units passes the level one cycle late
    assign limit = 16'(i_filt_units * `PHS_FILT_UNIT_CYC);

    // count while the raw level differs from the accepted one
    always_comb
    begin
        filt_next = filt_reg;
        cnt_next = `PHS_ZERO16;
        if (i_raw != filt_reg)
        begin
            if (cnt_reg >= limit)
                filt_next = i_raw;
            else
                cnt_next = cnt_reg + `PHS_ONE16;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            filt_reg <= 1'b0;
            cnt_reg <= 16'h0000;
        end
        else
        begin
            filt_reg <= filt_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_filt = filt_reg;
endmodule // phs_input_filter
`default_nettype wire

// ---- hdl/phs_homing_seq.sv ----
// homing sequencer for rear-end and count-type front-end proximity switch methods
`timescale 1ns/1ns
`default_nettype none
`include "phs_consts.svh"
// Operation
// - method digit 5 gives rear-end homing
// - method digit 6 gives front-end count homing
// - direction and switch polarity from parameter digits
// - homing speed until switch is seen
// - creep speed after switch seen
// - travel post-switch distance before fixing home
// - home shift added in both methods
// - homing acceleration constant applied throughout
// - position loaded from home data at completion
// - front mode: distances counted from front end
// - front end sampling sets home, speed dependent
// - every input except the move pulse delayed by filter time
// - rear mode: distances counted after rear end
module phs_homing_seq
    import phs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_auto_manual_select,
    input wire logic i_table_program_select_bit0,
    input wire logic i_table_program_select_bit1,
    input wire logic i_table_program_select_bit2,
    input wire logic i_program_mode,
    input wire logic i_homing_program_command,
    input wire logic i_start,
    input wire logic i_proximity_switch_input,
    input wire logic i_move_pulse,
    input wire logic [11:0] i_homing_method_param,
    input wire logic [15:0] i_homing_speed_param,
    input wire logic [15:0] i_creep_speed_param,
    input wire logic [31:0] i_home_shift_param,
    input wire logic [15:0] i_homing_accel_param,
    input wire logic [31:0] i_home_position_data_param,
    input wire logic [31:0] i_post_dog_travel_param,
    input wire logic [7:0] i_input_filter_time_param,
    output logic o_busy,
    output logic o_done,
    output logic o_move_dir,
    output logic [15:0] o_speed_cmd,
    output logic [15:0] o_accel_cmd,
    output logic o_pos_load,
    output logic [31:0] o_pos_value
);
    localparam int NIN = 7;
    logic [NIN-1:0] raw_in; // unfiltered external inputs
    logic [NIN-1:0] flt_in; // filtered copies
    logic f_auto, f_s0, f_s1, f_s2, f_prog, f_cmd, f_start;

    phs_state_t state_reg, state_next;
    logic dir_reg, dir_next;
    logic [15:0] speed_reg, speed_next;
    logic [15:0] accel_reg, accel_next;
    logic [31:0] remain_reg, remain_next; // pulses left to the home point
    logic load_reg, load_next;
    logic [31:0] posv_reg, posv_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic sw_prev_reg, sw_prev_next; // last switch level, for edges

    logic [3:0] method; // method digit of the parameter
    logic dog_on; // switch seen, polarity applied
    logic sel_ok;
    logic front_edge, rear_edge;

    // digit extraction used for method, direction and polarity
    function automatic logic [3:0] digit(input logic [11:0] p, input int lsb);
        digit = p[lsb +: 4];
    endfunction

    assign raw_in = {i_auto_manual_select, i_table_program_select_bit0,
        i_table_program_select_bit1, i_table_program_select_bit2,
        i_program_mode, i_homing_program_command, i_start};

    // every external input but the move pulse waits out the filter time
    genvar g;
    generate
        for (g = 0; g < NIN; g++)
        begin : g_filt
            phs_input_filter u_filt
            (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .i_filt_units(i_input_filter_time_param),
                .i_raw(raw_in[g]),
                .o_filt(flt_in[g])
            );
        end
    endgenerate

    // switch filter is separate so polarity applies after it
    logic f_sw;
    phs_input_filter u_sw_filt
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_filt_units(i_input_filter_time_param),
        .i_raw(i_proximity_switch_input),
        .o_filt(f_sw)
    );

    assign {f_auto, f_s0, f_s1, f_s2, f_prog, f_cmd, f_start} = flt_in;
    assign method = digit(i_homing_method_param, `PHS_DIG_METHOD_LSB);
    // polarity digit zero means switch active high
    assign dog_on = f_sw ^ (digit(i_homing_method_param, `PHS_DIG_POL_LSB) != 4'h0);
    // homing chosen by table selects all low or a program with the command
    assign sel_ok = f_auto && (f_prog ? f_cmd
        : ({f_s2, f_s1, f_s0} == `PHS_SEL_HOMING));
    assign front_edge = dog_on && !sw_prev_reg;
    assign rear_edge = !dog_on && sw_prev_reg;

    // sequencer next state; remaining distance counts on motion pulses
    always_comb
    begin
        state_next = state_reg;
        dir_next = dir_reg;
        speed_next = speed_reg;
        accel_next = accel_reg;
        remain_next = remain_reg;
        load_next = 1'b0;
        posv_next = posv_reg;
        busy_next = busy_reg;
        done_next = done_reg;
        sw_prev_next = dog_on;
        case (state_reg)
            PHS_IDLE:
            begin
                // only the two proximity methods start here
                if (f_start && sel_ok && (method == `PHS_METHOD_REAR
                    || method == `PHS_METHOD_FRONT))
                begin
                    state_next = PHS_FAST;
                    dir_next = digit(i_homing_method_param, `PHS_DIG_DIR_LSB) != 4'h0;
                    speed_next = i_homing_speed_param;
                    accel_next = i_homing_accel_param;
                    busy_next = 1'b1;
                    done_next = 1'b0;
                end
            end
            PHS_FAST:
            begin
                // front edge sampled here fixes where front-mode counting starts
                if (front_edge)
                begin
                    speed_next = i_creep_speed_param;
                    remain_next = 32'(i_post_dog_travel_param + i_home_shift_param);
                    state_next = (method == `PHS_METHOD_FRONT) ? PHS_TRAVEL
                        : PHS_WAIT_REAR;
                end
            end
            PHS_WAIT_REAR:
            begin
                // rear mode: distance counts only after the rear end
                if (rear_edge)
                    state_next = PHS_TRAVEL;
            end
            PHS_TRAVEL:
            begin
                if (remain_reg == `PHS_ZERO32)
                begin
                    state_next = PHS_DONE;
                    speed_next = `PHS_ZERO16;
                    load_next = 1'b1;
                    posv_next = i_home_position_data_param;
                end
                else if (i_move_pulse)
                    remain_next = remain_reg - 32'h00000001;
            end
            PHS_DONE:
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
                state_next = PHS_IDLE;
            end
            default:
                state_next = PHS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= PHS_IDLE;
            dir_reg <= 1'b0;
            speed_reg <= 16'h0000;
            accel_reg <= 16'h0000;
            remain_reg <= 32'h00000000;
            load_reg <= 1'b0;
            posv_reg <= 32'h00000000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            sw_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            dir_reg <= dir_next;
            speed_reg <= speed_next;
            accel_reg <= accel_next;
            remain_reg <= remain_next;
            load_reg <= load_next;
            posv_reg <= posv_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            sw_prev_reg <= sw_prev_next;
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_move_dir = dir_reg;
    assign o_speed_cmd = speed_reg;
    assign o_accel_cmd = accel_reg;
    assign o_pos_load = load_reg;
    assign o_pos_value = posv_reg;

    // creep speed follows the switch front edge within one cycle
    creep_after_dog_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_FAST && front_edge) |=> (speed_reg == $past(i_creep_speed_param)))
        else $error("creep speed not applied");
    // front mode skips the rear wait
    front_no_rear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_FAST && front_edge && method == `PHS_METHOD_FRONT)
        |=> state_reg == PHS_TRAVEL)
        else $error("front mode waited for rear end");
    rear_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_FAST && front_edge && method == `PHS_METHOD_REAR)
        |=> state_reg == PHS_WAIT_REAR)
        else $error("rear mode did not wait");
    sequence s_load;
        o_pos_load ##1 o_done;
    endsequence
    load_value_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_pos_load |-> o_pos_value == $past(i_home_position_data_param) ##0 s_load)
        else $error("home data not loaded");
    travel_dist_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_FAST && front_edge)
        |=> remain_reg == 32'($past(i_post_dog_travel_param) + $past(i_home_shift_param)))
        else $error("travel distance wrong");
    fast_speed_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_IDLE && $rose(busy_next))
        |=> speed_reg == $past(i_homing_speed_param) && accel_reg == $past(i_homing_accel_param))
        else $error("homing speed or accel wrong");
    method_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_IDLE && method != `PHS_METHOD_REAR && method != `PHS_METHOD_FRONT)
        |=> state_reg == PHS_IDLE)
        else $error("other method started");
    dir_digit_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_reg == PHS_IDLE && state_next == PHS_FAST)
        |=> o_move_dir == ($past(i_homing_method_param[7:4]) != 4'h0))
        else $error("direction digit ignored");
endmodule // phs_homing_seq
`default_nettype wire

// ---- tb/phs_axis_model.sv ----
// axis and proximity switch model facing the homing sequencer
`timescale 1ns/1ns
`default_nettype none
module phs_axis_model
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_clr,
    input wire logic [15:0] i_speed,
    input wire logic i_pol,
    output logic o_pulse,
    output logic o_switch,
    output logic [31:0] o_pos
);
    logic [4:0] div_reg; // slow rate keeps filter lag below one pulse
    logic act; // axis over the dog
    // one travel pulse every 32 cycles while a speed is commanded
    always @(negedge i_clk or negedge i_rst_b)
        if (!i_rst_b || i_clr)
        begin
            div_reg <= 5'h00;
            o_pulse <= 1'b0;
            o_pos <= 32'h00000000;
        end
        else
        begin
            div_reg <= (i_speed != 16'h0000) ? div_reg + 5'h01 : 5'h00;
            o_pulse <= (i_speed != 16'h0000) && (div_reg == 5'h1F);
            if (o_pulse)
                o_pos <= o_pos + 32'h00000001;
        end
    // dog spans positions 4 to 6
    assign act = (o_pos >= 32'h00000004) && (o_pos < 32'h00000007);
    assign o_switch = act ^ i_pol;
endmodule // phs_axis_model
`default_nettype wire

// ---- tb/phs_homing_seq_bench.sv ----
// self-checking bench for the proximity switch homing sequencer
`timescale 1ns/1ns
`default_nettype none
module phs_homing_seq_bench;
    import phs_pkg::*;
    typedef struct packed {
        logic [3:0] meth; logic pol; logic dir; logic [2:0] sel;
        logic man; logic pm; logic cmd; logic [7:0] trav; logic ok;
    } phs_row_t;
    localparam logic [15:0] HS = 16'h0300; // homing speed
    localparam logic [15:0] CS = 16'h0040; // creep speed
    localparam logic [15:0] AC = 16'h0123; // accel constant
    localparam logic [31:0] HD = 32'h0000ABCD; // home data
    localparam logic [31:0] SH = 32'h00000002; // home shift
    logic clk = 1'b0, rst_b = 1'b0, man, pm, cmd, start = 1'b0, clr = 1'b0;
    logic [2:0] sel;
    logic [11:0] meth;
    logic [7:0] filt = 8'h00, trav;
    logic sw, mp, busy, done, mdir, load;
    logic [15:0] spd, acc;
    logic [31:0] posv, apos;
    int failures = 0, compares = 0;
    phs_row_t rows[8] = '{
        '{4'h5, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 8'h05, 1'b1},
        '{4'h6, 1'b1, 1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b1},
        '{4'h6, 1'b0, 1'b0, 3'h5, 1'b1, 1'b1, 1'b1, 8'h03, 1'b1},
        '{4'h5, 1'b1, 1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 8'h02, 1'b1},
        '{4'h3, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 8'h02, 1'b0},
        '{4'h5, 1'b0, 1'b0, 3'h2, 1'b1, 1'b0, 1'b0, 8'h02, 1'b0},
        '{4'h6, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 8'h02, 1'b0},
        '{4'h5, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1, 1'b0, 8'h02, 1'b0}};
    // half period of the 50 ns clock
    always #25 clk = ~clk;
    phs_homing_seq phs_homing_seq_i (.i_clk(clk), .i_rst_b(rst_b),
        .i_auto_manual_select(man), .i_table_program_select_bit0(sel[0]),
        .i_table_program_select_bit1(sel[1]), .i_table_program_select_bit2(sel[2]),
        .i_program_mode(pm), .i_homing_program_command(cmd), .i_start(start),
        .i_proximity_switch_input(sw), .i_move_pulse(mp), .i_homing_method_param(meth),
        .i_homing_speed_param(HS), .i_creep_speed_param(CS), .i_home_shift_param(SH),
        .i_homing_accel_param(AC), .i_home_position_data_param(HD),
        .i_post_dog_travel_param({24'h000000, trav}), .i_input_filter_time_param(filt),
        .o_busy(busy), .o_done(done), .o_move_dir(mdir), .o_speed_cmd(spd),
        .o_accel_cmd(acc), .o_pos_load(load), .o_pos_value(posv));
    phs_axis_model phs_axis_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_clr(clr),
        .i_speed(spd), .i_pol(meth[8]), .o_pulse(mp), .o_switch(sw), .o_pos(apos));
    // verdict and end of run
    task automatic end_sim();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk1(input logic g, input logic e, input string m);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // bounded wait, sampled after the falling edge settles
    task automatic wait_on(input int k, input int lim, output logic hit);
        hit = 1'b0;
        repeat (lim)
        begin
            @(negedge clk);
            #5;
            if ((k == 0 && busy === 1'b1) || (k == 1 && spd === CS) || (k == 2 && load === 1'b1))
            begin
                hit = 1'b1;
                break;
            end
        end
    endtask
    task automatic need(input int k, input int lim);
        logic hit;
        wait_on(k, lim, hit);
        chk1(hit, 1'b1, "wait ran out");
        if (!hit)
            end_sim();
    endtask
    // one homing attempt from a table row
    task automatic run_row(input phs_row_t r);
        logic hit;
        logic [31:0] e;
        @(negedge clk);
        clr = 1'b1;
        trav = r.trav;
        meth = {3'h0, r.pol, 3'h0, r.dir, r.meth};
        man = r.man;
        sel = r.sel;
        pm = r.pm;
        cmd = r.cmd;
        @(negedge clk);
        clr = 1'b0;
        start = 1'b1;
        wait_on(0, 60, hit);
        chk1(hit, r.ok, "start acceptance");
        start = 1'b0;
        if (hit)
        begin
            chk32({16'h0000, spd}, {16'h0000, HS}, "homing speed");
            chk32({16'h0000, acc}, {16'h0000, AC}, "accel");
            chk1(mdir, r.dir, "direction");
            need(1, 2000);
            chk32(apos, 32'h00000004, "creep at front end");
            need(2, 4000);
            chk32(posv, HD, "position data");
            chk32({16'h0000, spd}, 32'h00000000, "stop");
            e = ((r.meth == 4'h5) ? 32'h00000007 : 32'h00000004) + r.trav + SH;
            chk1(apos - e <= 32'h00000001, 1'b1, "home point");
            @(negedge clk);
            #5;
            chk1(done, 1'b1, "done");
            chk1(busy, 1'b0, "busy after done");
        end
    endtask
    initial
    begin
        logic hit;
        man = 1'b1; sel = 3'h0; pm = 1'b0; cmd = 1'b0; trav = 8'h02; meth = 12'h005;
        repeat (12) @(negedge clk);
        chk1(busy | done | load, 1'b0, "reset outputs");
        rst_b = 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        // filter of 2 units holds start back 42 cycles
        filt = 8'h02;
        meth = 12'h006;
        // last table row left program mode without the command selected
        man = 1'b1;
        sel = 3'h0;
        pm = 1'b0;
        cmd = 1'b0;
        start = 1'b1;
        wait_on(0, 38, hit);
        chk1(hit, 1'b0, "filter too short");
        wait_on(0, 12, hit);
        chk1(hit, 1'b1, "filter too long");
        start = 1'b0;
        need(2, 4000);
        filt = 8'h00;
        // reset in mid-run clears the outputs
        @(negedge clk);
        start = 1'b1;
        need(0, 60);
        start = 1'b0;
        rst_b = 1'b0;
        #5;
        chk1(busy | done, 1'b0, "mid-run reset");
        chk32({16'h0000, spd}, 32'h00000000, "speed after reset");
        @(negedge clk);
        rst_b = 1'b1;
        run_row(rows[0]);
        end_sim();
    end
endmodule // phs_homing_seq_bench
`default_nettype wire
